// >>> rwc_pkg.sv
// How it works
// - Primary-idle wake never starts crystal startup timer
// - Non-crystal primary modes skip crystal startup timer
// - Every wake inserts prep delay, then resumes
// - Prep delay overlaps other wake delays
// - Primary-idle wake waits prep only, flags ready
// - Exit delay chosen by target clock type
// - PLL lock wait uses its own timer
// - Any reset selects internal oscillator 1 MHz
// - Eight reset causes are told apart
// - Low five bits are event-cleared cause flags
// - Bit 7 enables interrupt priority, resets 0
// - Bit 6 acts only when config is 01
// - Bit 6 reset value follows config; bit5 zero
// - Reset instruction clears bit 4; software sets
// - Bit 3 set by power/clear/sleep, cleared by timeout
// - Bit 2 set by power/clear, cleared by sleep
// - Bit 1 cleared only by power-on reset
// - Bit 0 cleared by brown-out or power-on reset
// - Master-clear pin low resets, short pulses filtered
// - Master-clear pin is never driven by device
// - Disabled master-clear pin is plain input
// - Crystal startup timer counts 1024 cycles
// - PLL lock wait follows startup, 2 ms
// Constants, enums and carrier structs for the reset and wake sequencer.
// Assumes a single 125 MHz clock and an AXI4-Lite register master.
package rwc_pkg;
   // Register byte addresses
   localparam logic [7:0]  ADDR_RESET_CONTROL = 8'h00;
   localparam logic [7:0]  ADDR_WAKE_CONTROL  = 8'h04;
   localparam logic [7:0]  ADDR_STATUS        = 8'h08;
   localparam logic [1:0]  RESP_OKAY          = 2'h0;
   localparam logic [1:0]  RESP_SLVERR        = 2'h2;
   // Reset-control bit positions
   localparam int BIT_IRQ_PRIO   = 7;
   localparam int BIT_SW_BROWN   = 6;
   localparam int BIT_RST_INSTR  = 4;
   localparam int BIT_WDT_FLAG   = 3;
   localparam int BIT_PWR_DOWN   = 2;
   localparam int BIT_POWER_ON   = 1;
   localparam int BIT_BROWN_FLAG = 0;
   localparam logic [1:0]  BROWNOUT_CFG_OFF = 2'h0;
   localparam logic [1:0]  BROWNOUT_CFG_SW  = 2'h1;
   localparam logic [1:0]  BROWNOUT_CFG_RUN = 2'h2;
   // Internal oscillator mux code for 1 MHz (code chosen here)
   localparam logic [2:0]  INTERNAL_OSC_MUX_SEL_1MHZ = 3'h4;
   // Timing
   localparam int CLK_PERIOD_NS      = 8;
   localparam int OST_OSC_CYCLES     = 1024;
   localparam int PLL_LOCK_NS        = 2000000;
   localparam int PLL_LOCK_CYCLES    = PLL_LOCK_NS / CLK_PERIOD_NS;
   localparam int WAKE_PREP_CYCLES   = 8;
   localparam int MASTER_CLEAR_PIN_FILTER_CYCLES = 4;
   // Reset cause one-hot positions
   localparam int CAUSE_POWER_ON  = 0;
   localparam int CAUSE_MASTER_CLEAR_PIN_RUN  = 1;
   localparam int CAUSE_MASTER_CLEAR_PIN_PM   = 2;
   localparam int CAUSE_WATCHDOG  = 3;
   localparam int CAUSE_BROWNOUT  = 4;
   localparam int CAUSE_RST_INSTR = 5;
   localparam int CAUSE_STK_FULL  = 6;
   localparam int CAUSE_STK_UNDER = 7;

   typedef enum logic [4:0] {
      ST_RUN       = 5'b0_0001,
      ST_POWERDOWN = 5'b0_0010,
      ST_OST       = 5'b0_0100,
      ST_PLL       = 5'b0_1000,
      ST_PREP      = 5'b1_0000
   } rwc_fsm_t;

   // Clock source in use while powered down
   typedef enum logic [1:0] {
      SRC_PRIMARY_IDLE = 2'h0,
      SRC_SECONDARY    = 2'h1,
      SRC_INTERNAL     = 2'h2,
      SRC_SLEEP        = 2'h3
   } rwc_src_t;

   typedef enum logic [2:0] {
      OSC_LOW_POWER_CRYSTAL = 3'h0,
      OSC_STANDARD_CRYSTAL  = 3'h1,
      OSC_HIGH_SPEED        = 3'h2,
      OSC_HIGH_SPEED_X4     = 3'h3,
      OSC_EXTERNAL_CLOCK    = 3'h4,
      OSC_RES_CAP           = 3'h5,
      OSC_INTERNAL_IO       = 3'h6
   } rwc_osc_t;

   typedef struct packed {
      rwc_osc_t   osc_mode;
      logic [1:0] brownout_config;
      logic       master_clear_pin_enable;
      logic       wake_to_internal;
   } rwc_cfg_t;

   typedef struct packed {
      logic sleep_instr;
      logic watchdog_clear_instr;
      logic reset_instr;
      logic watchdog_timeout;
      logic brownout_detect;
      logic stack_full;
      logic stack_underflow;
      logic wake_irq;
   } rwc_evt_t;

   typedef struct packed {
      rwc_fsm_t    fsm;
      rwc_src_t    src;
      logic [19:0] osc_cnt;
      logic [7:0]  prep_cnt;
      logic        irq_priority_enable;
      logic        sw_brownout_enable;
      logic        reset_instr_flag;
      logic        watchdog_timeout_flag;
      logic        power_down_flag;
      logic        power_on_flag;
      logic        brownout_flag;
      logic [2:0]  osc_sel;
      logic        primary_clock_ready_flag;
      logic        internal_clock_stable_flag;
      logic [7:0]  cause;
      logic [2:0]  master_clear_pin_cnt;
      logic        master_clear_pin_hit;
      logic        dev_reset;
      logic        init;
      logic        aw_ok;
      logic [7:0]  aw_addr;
      logic        w_ok;
      logic [7:0]  wdata;
      logic        wstrb0;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } rwc_state_t;
endpackage

// >>> rwc_reset_wake.sv
// Reset combining, reset-control register and wake exit-delay sequencer.
// Assumes event inputs are one-cycle pulses synchronous to clk and that
// rst_n is the power-on reset of the block.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rwc_reset_wake import rwc_pkg::*; #(
   parameter int unsigned OST_CYCLES  = OST_OSC_CYCLES,
   parameter int unsigned PLL_CYCLES  = PLL_LOCK_CYCLES,
   parameter int unsigned PREP_CYCLES = WAKE_PREP_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire rwc_cfg_t    cfg,
   input  wire rwc_evt_t    evt,
   input  wire rwc_src_t    pm_source,
   input  wire logic        master_clear_pin_n,
   output logic             master_clear_pin_oe,
   output logic             master_clear_digital_in,
   output logic             device_reset,
   output logic             cpu_run,
   output logic             brownout_enable,
   output logic             irq_priority_enable,
   output logic [2:0]       internal_osc_sel,
   output logic             primary_clock_ready_flag,
   output logic             internal_clock_stable_flag,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   rwc_state_t s;
   rwc_state_t next_s;

   // Crystal modes are the only ones that need the startup timer
   function automatic logic is_crystal(input rwc_osc_t m);
      return (m == OSC_LOW_POWER_CRYSTAL) || (m == OSC_STANDARD_CRYSTAL) ||
             (m == OSC_HIGH_SPEED) || (m == OSC_HIGH_SPEED_X4);
   endfunction

   logic       bo_on;
   logic       master_clear_pin_low;
   logic       master_clear_pin_fire;
   logic       wdt_rst;
   logic       bo_rst;
   logic       any_rst;
   logic       wake_go;
   logic       need_ost;
   logic       need_pll;
   logic       wr_go;
   logic [7:0] rc_read;

   // Brown-out enable per configuration field
   always_comb begin
      unique case (cfg.brownout_config)
         BROWNOUT_CFG_OFF: bo_on = 1'b0;
         BROWNOUT_CFG_SW:  bo_on = s.sw_brownout_enable;
         BROWNOUT_CFG_RUN: bo_on = (s.fsm != ST_POWERDOWN);
         default:          bo_on = 1'b1;
      endcase
   end

   // Reset causes and wake decision
   assign master_clear_pin_low  = cfg.master_clear_pin_enable && !master_clear_pin_n;
   assign master_clear_pin_fire = master_clear_pin_low && !s.master_clear_pin_hit &&
                      (s.master_clear_pin_cnt == 3'(MASTER_CLEAR_PIN_FILTER_CYCLES - 1));
   assign wdt_rst   = evt.watchdog_timeout && (s.fsm == ST_RUN);
   assign bo_rst    = evt.brownout_detect && bo_on;
   assign any_rst   = master_clear_pin_fire || wdt_rst || bo_rst || evt.reset_instr ||
                      evt.stack_full || evt.stack_underflow;
   assign wake_go   = (s.fsm == ST_POWERDOWN) &&
                      (evt.wake_irq || evt.watchdog_timeout);
   // Primary idle keeps the oscillator running, so no startup wait
   assign need_ost  = !cfg.wake_to_internal && is_crystal(cfg.osc_mode) &&
                      (s.src != SRC_PRIMARY_IDLE);
   assign need_pll  = need_ost && (cfg.osc_mode == OSC_HIGH_SPEED_X4);
   assign wr_go     = s.aw_ok && s.w_ok && !s.bvalid;

   // Read view: bit 5 is always zero, bit 6 only live in software mode
   always_comb begin
      rc_read = 8'h00;
      rc_read[BIT_IRQ_PRIO]   = s.irq_priority_enable;
      rc_read[BIT_SW_BROWN]   = s.sw_brownout_enable &&
                                (cfg.brownout_config == BROWNOUT_CFG_SW);
      rc_read[BIT_RST_INSTR]  = s.reset_instr_flag;
      rc_read[BIT_WDT_FLAG]   = s.watchdog_timeout_flag;
      rc_read[BIT_PWR_DOWN]   = s.power_down_flag;
      rc_read[BIT_POWER_ON]   = s.power_on_flag;
      rc_read[BIT_BROWN_FLAG] = s.brownout_flag;
   end

   // Next state of the whole block
   always_comb begin
      next_s = s;
      next_s.dev_reset = s.master_clear_pin_hit && master_clear_pin_low;
      next_s.init = 1'b0;
      if (s.init) begin
         next_s.sw_brownout_enable =
            (cfg.brownout_config == BROWNOUT_CFG_SW);
      end
      if (s.prep_cnt != 8'h00) begin
         next_s.prep_cnt = s.prep_cnt - 8'h01;
      end
      // Master-clear glitch filter
      if (master_clear_pin_low) begin
         if (s.master_clear_pin_cnt != 3'(MASTER_CLEAR_PIN_FILTER_CYCLES - 1)) begin
            next_s.master_clear_pin_cnt = s.master_clear_pin_cnt + 3'h1;
         end
         if (master_clear_pin_fire) begin
            next_s.master_clear_pin_hit = 1'b1;
         end
      end else begin
         next_s.master_clear_pin_cnt = 3'h0;
         next_s.master_clear_pin_hit = 1'b0;
      end
      // Wake sequencer
      unique case (s.fsm)
         ST_RUN: begin
            if (evt.sleep_instr) begin
               next_s.fsm = ST_POWERDOWN;
               next_s.src = pm_source;
               if (pm_source != SRC_PRIMARY_IDLE) begin
                  next_s.primary_clock_ready_flag = 1'b0;
               end
               if (pm_source == SRC_SLEEP) begin
                  next_s.internal_clock_stable_flag = 1'b0;
               end
            end
         end
         ST_POWERDOWN: begin
            if (wake_go) begin
               next_s.prep_cnt = 8'(PREP_CYCLES);
               if (need_ost) begin
                  next_s.fsm = ST_OST;
                  next_s.osc_cnt = 20'(OST_CYCLES);
               end else begin
                  next_s.fsm = ST_PREP;
               end
            end
         end
         ST_OST: begin
            next_s.osc_cnt = s.osc_cnt - 20'h1;
            if (s.osc_cnt <= 20'h1) begin
               if (need_pll) begin
                  next_s.fsm = ST_PLL;
                  next_s.osc_cnt = 20'(PLL_CYCLES);
               end else if (s.prep_cnt <= 8'h01) begin
                  next_s.fsm = ST_RUN;
               end else begin
                  next_s.fsm = ST_PREP;
               end
            end
         end
         ST_PLL: begin
            next_s.osc_cnt = s.osc_cnt - 20'h1;
            if (s.osc_cnt <= 20'h1) begin
               next_s.fsm = (s.prep_cnt <= 8'h01) ? ST_RUN : ST_PREP;
            end
         end
         ST_PREP: begin
            if (s.prep_cnt <= 8'h01) begin
               next_s.fsm = ST_RUN;
            end
         end
      endcase
      // Ready flags follow the target clock on resume
      if (s.fsm != ST_RUN && next_s.fsm == ST_RUN) begin
         if (cfg.wake_to_internal) begin
            next_s.internal_clock_stable_flag = 1'b1;
         end else begin
            next_s.primary_clock_ready_flag = 1'b1;
         end
      end
      // Instruction effects on status flags
      if (evt.watchdog_clear_instr) begin
         next_s.watchdog_timeout_flag = 1'b1;
         next_s.power_down_flag = 1'b1;
      end
      if (evt.sleep_instr && s.fsm == ST_RUN) begin
         next_s.watchdog_timeout_flag = 1'b1;
         next_s.power_down_flag = 1'b0;
      end
      // AXI4-Lite channels: one write and one read at a time
      if (s_axi_awvalid && s_axi_awready) begin
         next_s.aw_ok = 1'b1;
         next_s.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_s.w_ok = 1'b1;
         next_s.wdata = s_axi_wdata[7:0];
         next_s.wstrb0 = s_axi_wstrb[0];
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (wr_go) begin
         next_s.aw_ok = 1'b0;
         next_s.w_ok = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = RESP_OKAY;
         if (s.aw_addr == ADDR_RESET_CONTROL) begin
            if (s.wstrb0) begin
               next_s.irq_priority_enable = s.wdata[BIT_IRQ_PRIO];
               if (cfg.brownout_config == BROWNOUT_CFG_SW) begin
                  next_s.sw_brownout_enable = s.wdata[BIT_SW_BROWN];
               end
               next_s.reset_instr_flag = s.wdata[BIT_RST_INSTR];
               next_s.power_on_flag = s.wdata[BIT_POWER_ON];
               next_s.brownout_flag = s.wdata[BIT_BROWN_FLAG];
            end
         end else if (s.aw_addr == ADDR_WAKE_CONTROL) begin
            if (s.wstrb0) begin
               next_s.osc_sel = s.wdata[2:0];
            end
         end else if (s.aw_addr != ADDR_STATUS) begin
            next_s.bresp = RESP_SLVERR;
         end
      end
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = RESP_OKAY;
         unique case (s_axi_araddr)
            ADDR_RESET_CONTROL: next_s.rdata = {24'h00_0000, rc_read};
            ADDR_WAKE_CONTROL:  next_s.rdata = {29'h0000_0000, s.osc_sel};
            ADDR_STATUS: begin
               next_s.rdata = {16'h0000, s.cause, 1'b0, s.fsm,
                               s.internal_clock_stable_flag,
                               s.primary_clock_ready_flag};
            end
            default: begin
               next_s.rdata = 32'h0000_0000;
               next_s.rresp = RESP_SLVERR;
            end
         endcase
      end
      // Timeout clears its flag even when it only wakes the core
      if (evt.watchdog_timeout) begin
         next_s.watchdog_timeout_flag = 1'b0;
      end
      // Internal resets win over software writes of the same cycle
      if (any_rst) begin
         next_s.dev_reset = 1'b1;
         next_s.fsm = ST_RUN;
         next_s.osc_cnt = 20'h0;
         next_s.prep_cnt = 8'h00;
         next_s.osc_sel = INTERNAL_OSC_MUX_SEL_1MHZ;
         next_s.irq_priority_enable = 1'b0;
         next_s.sw_brownout_enable =
            (cfg.brownout_config == BROWNOUT_CFG_SW);
         next_s.cause = 8'h00;
         if (master_clear_pin_fire) begin
            next_s.cause[(s.fsm == ST_RUN) ? CAUSE_MASTER_CLEAR_PIN_RUN
                                           : CAUSE_MASTER_CLEAR_PIN_PM] = 1'b1;
         end else if (bo_rst) begin
            next_s.cause[CAUSE_BROWNOUT] = 1'b1;
         end else if (wdt_rst) begin
            next_s.cause[CAUSE_WATCHDOG] = 1'b1;
         end else if (evt.reset_instr) begin
            next_s.cause[CAUSE_RST_INSTR] = 1'b1;
         end else if (evt.stack_full) begin
            next_s.cause[CAUSE_STK_FULL] = 1'b1;
         end else begin
            next_s.cause[CAUSE_STK_UNDER] = 1'b1;
         end
         if (evt.reset_instr) begin
            next_s.reset_instr_flag = 1'b0;
         end
         if (bo_rst) begin
            next_s.brownout_flag = 1'b0;
         end
      end
   end

   // State register; power-on is the asynchronous reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.fsm <= ST_RUN;
         s.src <= SRC_PRIMARY_IDLE;
         s.reset_instr_flag <= 1'b1;
         s.watchdog_timeout_flag <= 1'b1;
         s.power_down_flag <= 1'b1;
         s.power_on_flag <= 1'b0;
         s.osc_sel <= INTERNAL_OSC_MUX_SEL_1MHZ;
         s.cause <= 8'h01;
         s.dev_reset <= 1'b1;
         s.init <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // Outputs; the pin is input only and is never driven
   assign master_clear_pin_oe        = 1'b0;
   assign master_clear_digital_in    = master_clear_pin_n;
   assign device_reset               = s.dev_reset;
   assign cpu_run                    = (s.fsm == ST_RUN) && !s.dev_reset;
   assign brownout_enable            = bo_on;
   assign irq_priority_enable        = s.irq_priority_enable;
   assign internal_osc_sel           = s.osc_sel;
   assign primary_clock_ready_flag   = s.primary_clock_ready_flag;
   assign internal_clock_stable_flag = s.internal_clock_stable_flag;
   assign s_axi_awready              = !s.aw_ok && !s.bvalid;
   assign s_axi_wready               = !s.w_ok && !s.bvalid;
   assign s_axi_bvalid               = s.bvalid;
   assign s_axi_bresp                = s.bresp;
   assign s_axi_arready              = !s.rvalid;
   assign s_axi_rvalid               = s.rvalid;
   assign s_axi_rdata                = s.rdata;
   assign s_axi_rresp                = s.rresp;

   // Checking helpers: cycles since wake and the delay expected
   logic        h_woke;
   logic [23:0] h_cnt;
   logic [23:0] h_exp;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         h_woke <= 1'b0;
         h_cnt <= 24'h0;
         h_exp <= 24'h0;
      end else if (wake_go && !any_rst) begin
         h_woke <= 1'b1;
         h_cnt <= 24'h0;
         h_exp <= 24'(PREP_CYCLES);
         if (need_ost && 24'(OST_CYCLES + (need_pll ? PLL_CYCLES : 0)) >
                         24'(PREP_CYCLES)) begin
            h_exp <= 24'(OST_CYCLES + (need_pll ? PLL_CYCLES : 0));
         end
      end else begin
         h_cnt <= h_cnt + 24'h1;
         if (s.fsm == ST_RUN || any_rst) begin
            h_woke <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence master_clear_pin_held_s;
      (cfg.master_clear_pin_enable && !master_clear_pin_n) [*4];
   endsequence
   sequence idle_wake_s;
      wake_go && !any_rst && s.src == SRC_PRIMARY_IDLE;
   endsequence

   chk_exit_delay_total: assert property (
      h_woke && s.fsm == ST_RUN && !s.dev_reset |-> h_cnt == h_exp)
      else $error("wake exit delay differs from expected");
   chk_idle_prep_only: assert property (
      idle_wake_s |=> s.fsm == ST_PREP && s.prep_cnt == 8'(PREP_CYCLES))
      else $error("primary idle wake did not go straight to prep");
   chk_nonxtal_skip_ost: assert property (
      wake_go && !any_rst && !is_crystal(cfg.osc_mode) |=> s.fsm != ST_OST)
      else $error("non-crystal wake started startup timer");
   chk_pll_after_ost: assert property (
      s.fsm == ST_OST && s.osc_cnt == 20'h1 && need_pll && !any_rst
      |=> s.fsm == ST_PLL && s.osc_cnt == 20'(PLL_CYCLES))
      else $error("lock wait did not follow startup timer");
   chk_osc_default: assert property (
      any_rst |=> internal_osc_sel == INTERNAL_OSC_MUX_SEL_1MHZ && device_reset)
      else $error("oscillator select not defaulted by reset");
   chk_instr_flag_clear: assert property (
      evt.reset_instr |=> !s.reset_instr_flag && s.cause[CAUSE_RST_INSTR]
      || s.cause[CAUSE_MASTER_CLEAR_PIN_RUN] || s.cause[CAUSE_MASTER_CLEAR_PIN_PM]
      || s.cause[CAUSE_BROWNOUT] || s.cause[CAUSE_WATCHDOG])
      else $error("reset instruction flag not cleared");
   chk_sleep_flags: assert property (
      evt.sleep_instr && s.fsm == ST_RUN && !evt.watchdog_timeout &&
      !evt.watchdog_clear_instr && !any_rst
      |=> s.watchdog_timeout_flag && !s.power_down_flag &&
          s.fsm == ST_POWERDOWN)
      else $error("sleep did not update power flags");
   chk_master_clear_pin_filter: assert property (
      master_clear_pin_held_s |=> device_reset)
      else $error("held master clear did not reset");
   chk_master_clear_pin_undriven: assert property (
      !master_clear_pin_oe)
      else $error("master clear pin driven");
   chk_master_clear_pin_disabled: assert property (
      !cfg.master_clear_pin_enable |=> s.master_clear_pin_cnt == 3'h0 && !s.master_clear_pin_hit)
      else $error("disabled master clear counted");
   chk_brownout_bit: assert property (
      cfg.brownout_config != BROWNOUT_CFG_SW |-> !rc_read[BIT_SW_BROWN])
      else $error("software brown-out bit visible outside mode 01");
endmodule
`default_nettype wire

// >>> rwc_master_clear_pin_drv.sv
// Board-side model of the master-clear pin and its pull-up.
// Assumes press() is called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module rwc_master_clear_pin_drv (
   input  wire logic clk,
   output logic      pin_n
);
   initial pin_n = 1'b1; // Pull-up holds the pin high when released
   // Hold low for n sampled edges; short holds probe the noise filter
   task automatic press(input int n);
      pin_n <= 1'b0;
      repeat (n) @(posedge clk);
      pin_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the reset and wake sequencer.
// Assumes short wake parameters; reads are checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module tb import rwc_pkg::*;;
   localparam int CRYSTAL_STARTUP_TIMER = 20, PLL = 20, PRE = 8;
   logic clk = 0, rst_n = 0, saw = 0, master_clear_pin_n;
   logic master_clear_pin_oe, master_clear_digital_in, device_reset;
   logic cpu_run, brownout_enable, irq_priority_enable;
   logic primary_clock_ready_flag, internal_clock_stable_flag;
   logic [2:0] internal_osc_sel;
   rwc_cfg_t cfg = '{OSC_HIGH_SPEED, 2'h1, 1'b1, 1'b0};
   rwc_evt_t evt = '0;
   rwc_src_t pm_source = SRC_SLEEP;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, qd[$], qm[$];
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, qr[$], qb[$];
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int n_errors = 0, comparisons = 0, n;
   rwc_osc_t md[6] = '{OSC_HIGH_SPEED, OSC_HIGH_SPEED, OSC_HIGH_SPEED_X4,
                       OSC_EXTERNAL_CLOCK, OSC_RES_CAP, OSC_HIGH_SPEED};
   rwc_src_t sr[6] = '{SRC_PRIMARY_IDLE, SRC_SLEEP, SRC_SECONDARY,
                       SRC_INTERNAL, SRC_SLEEP, SRC_SLEEP};
   int ex[6] = '{PRE + 1, CRYSTAL_STARTUP_TIMER + 1, CRYSTAL_STARTUP_TIMER + PLL + 1, PRE + 1, PRE + 1, PRE + 1};
   rwc_reset_wake #(.OST_CYCLES(CRYSTAL_STARTUP_TIMER), .PLL_CYCLES(PLL),
                    .PREP_CYCLES(PRE)) u_dut (.*);
   rwc_master_clear_pin_drv u_master_clear_pin (.clk(clk), .pin_n(master_clear_pin_n));
   initial forever #4 clk = ~clk;
   // Sticky witness of any device reset since the last clear
   always @(posedge clk) if (device_reset) saw = 1;
   // Read data and responses are judged against the oldest noted ones
   always @(posedge clk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         chk(s_axi_rdata & qm.pop_front(), qd.pop_front());
         chk(s_axi_rresp, qr.pop_front());
      end
      if (s_axi_bvalid && s_axi_bready)
         chk(s_axi_bresp, qb.pop_front());
      if (!cfg.master_clear_pin_enable)
         chk(master_clear_digital_in, master_clear_pin_n);
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic close_out();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Mapped offsets answer OKAY, anything else a slave error
   function automatic logic [1:0] xresp(input logic [7:0] a);
      return (a inside {ADDR_RESET_CONTROL, ADDR_WAKE_CONTROL, ADDR_STATUS})
         ? RESP_OKAY : RESP_SLVERR;
   endfunction
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw = 1, w = 1;
      qb.push_back(xresp(a));
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (aw || w) begin
         @(posedge clk);
         if (s_axi_awready) aw = 0;
         if (s_axi_wready) w = 0;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      while (!s_axi_bvalid) @(posedge clk);
      s_axi_bready <= 0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
      qd.push_back(e);
      qm.push_back(m);
      qr.push_back(xresp(a));
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 0;
      @(posedge clk);
   endtask
   // One-cycle event pulse, then whether a reset followed
   task automatic ev(input logic [7:0] e, input logic r);
      saw = 0;
      evt <= e;
      @(posedge clk);
      evt <= '0;
      repeat (5) @(posedge clk);
      chk(saw, r);
   endtask
   task automatic mc(input int k, input logic r);
      saw = 0;
      u_master_clear_pin.press(k);
      repeat (4) @(posedge clk);
      chk(saw, r);
   endtask
   initial begin
      void'($urandom(94));
      repeat (3) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      chk(internal_osc_sel, INTERNAL_OSC_MUX_SEL_1MHZ);
      rd(ADDR_RESET_CONTROL, 8'h5C, 8'hFF);
      wr(ADDR_RESET_CONTROL, $urandom & 32'hFFFF_FF00 | 8'hFF);
      rd(ADDR_RESET_CONTROL, 8'hDF, 8'hFF);
      chk(irq_priority_enable, 1);
      rd(8'h0C, '0, '1);
      wr(8'h0C, '1);
      // Sleep and wake over the table of sources and targets
      for (int i = 0; i < 6; i++) begin
         cfg.osc_mode <= md[i];
         cfg.wake_to_internal <= (i == 5);
         pm_source <= sr[i];
         ev(8'h80, 0);
         evt <= (i > 3) ? 8'h10 : 8'h01;
         n = 0;
         do begin
            @(posedge clk);
            evt <= '0;
            #1 n++;
         end while (!cpu_run && n < 99);
         chk(n, ex[i]);
         chk(primary_clock_ready_flag, i != 5);
         chk(internal_clock_stable_flag, i == 5);
         @(posedge clk);
      end
      rd(ADDR_RESET_CONTROL, 8'hD3, 8'hFF);
      ev(8'h40, 0);
      wr(ADDR_RESET_CONTROL, 8'hDF);
      ev(8'h20, 1);
      rd(ADDR_RESET_CONTROL, 8'h0F, 8'hBF);
      wr(ADDR_RESET_CONTROL, 8'hDF);
      ev(8'h08, 1);
      rd(ADDR_RESET_CONTROL, 8'h1E, 8'hBF);
      ev(8'h10, 1);
      rd(ADDR_RESET_CONTROL, 8'h16, 8'hBF);
      rd(ADDR_STATUS, {16'h0000, 8'h08, 1'b0, ST_RUN, 2'b10}, '1);
      wr(ADDR_WAKE_CONTROL, 32'h0000_0002);
      rd(ADDR_WAKE_CONTROL, 32'h0000_0002, '1);
      ev(8'h04, 1);
      ev(8'h02, 1);
      chk(internal_osc_sel, INTERNAL_OSC_MUX_SEL_1MHZ);
      mc(3, 0);
      mc(6, 1);
      chk(master_clear_pin_oe, 0);
      cfg.master_clear_pin_enable <= 0;
      mc(6, 0);
      // Bit 6 is inert outside software brown-out control
      cfg.brownout_config <= BROWNOUT_CFG_RUN;
      wr(ADDR_RESET_CONTROL, 8'h1F);
      chk(brownout_enable, 1);
      ev(8'h08, 1);
      rd(ADDR_RESET_CONTROL, 8'h00, 8'h40);
      cfg.brownout_config <= BROWNOUT_CFG_OFF;
      ev(8'h08, 0);
      chk(brownout_enable, 0);
      close_out();
   end
   // Hang guard, far beyond the expected run
   initial begin
      #200us;
      n_errors++;
      close_out();
   end
endmodule
`default_nettype wire
